// ==== common/adc_seq_defs.svh ====
// Purpose: Constants for the serial control sequencer
// Assumes: 40 MHz system clock
// Notes: Bit positions refer to the 8-bit control byte
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define BIT_START 7
`define BIT_POLARITY 6
`define BIT_CLKSRC 5
`define BIT_MODE_HI 4
`define BIT_MODE_LO 3
`define MODE_SHORT 2'h0
`define MODE_CAL 2'h1
`define MODE_PWRDN 2'h2
`define MODE_LONG 2'h3
`define CLKS_SHORT 24
`define CLKS_LONG 32
`define RESULT_BITS 16
`define STROBE_MAX_NS 6000
`define CLK_PERIOD_NS 25
`define CONV_CYCLES (`STROBE_MAX_NS / `CLK_PERIOD_NS)
`define CAL_CYCLES 80000
`endif

// ==== common/adc_seq_pkg.sv ====
// Purpose: Types for the serial control sequencer
// Assumes: Nothing beyond the defs header
// Notes: Control byte carried as a packed struct
package adc_seq_pkg;
  typedef struct packed {
    logic start;
    logic polarity;
    logic clockSource;
    logic [1:0] mode;
    logic [2:0] userOut;
  } ctrl_byte_type;
  typedef enum logic [1:0] {ACQ_SHORT, ACQ_CAL, ACQ_PWRDN, ACQ_LONG} mode_type;
endpackage

// ==== hdl/sync_two_ff.sv ====
// Purpose: Two-flop level synchroniser
// Assumes: Input asynchronous to clk
// Notes: First stage read only by second stage
`timescale 1ns/10ps
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // Destination clock
  input wire logic rstn, // Async reset, active low
  input wire logic [WIDTH-1:0] din, // Asynchronous level
  output logic [WIDTH-1:0] dout // Synchronised level
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// ==== hdl/adc_serial_control_sequencer.sv ====
// Purpose: Serial control byte framing, conversion sequencing, result shift-out
// Assumes: Serial clock from host is its own domain; conversion core runs on clk
// Notes: External-clock conversion timing is not modelled; analog result is an input
`timescale 1ns/10ps
`include "adc_seq_defs.svh"
module adc_serial_control_sequencer #(
  parameter int CONV_CYCLES = `CONV_CYCLES,
  parameter int CAL_CYCLES = `CAL_CYCLES
) (
  input wire logic clk, // System clock 40 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic serialClk, // Host serial clock
  input wire logic chipSelectN, // Chip select, active low
  input wire logic serialIn, // Serial data in
  input wire logic shutdown_n, // Hardware shutdown, active low
  input wire logic [15:0] analogSample, // Raw converter result, offset binary
  output logic serialOut, // Serial data out
  output logic serialOutEn, // Output enable of serial data out
  output logic conversion_strobe, // Conversion strobe
  output logic [2:0] userOut, // General-purpose outputs
  output logic polarity_select, // Latched polarity
  output logic clock_source_select, // Latched clock source
  output logic powerDown, // Power-down state, set by software power-down or the hardware shutdown pin
  output logic calibrating // Calibration in progress
);
  // Serial domain: byte assembly on rising edges
  logic [6:0] shift_q, shift_d;
  logic [2:0] bitCnt_q, bitCnt_d;
  logic framing_q, framing_d;
  logic armed_q, armed_d;
  logic byteTgl_q, byteTgl_d;
  logic [7:0] byteHold_q, byteHold_d;
  logic sclkIdle;

  always_comb begin
    shift_d = shift_q;
    bitCnt_d = bitCnt_q;
    framing_d = framing_q;
    armed_d = armed_q;
    byteHold_d = byteHold_q;
    if (!chipSelectN) begin
      if (!framing_q) begin
        if (serialIn && (armed_q || sclkIdle)) begin
          framing_d = 1'b1;
          armed_d = 1'b0;
          shift_d = 7'h01;
          bitCnt_d = 3'h1;
        end
      end else begin
        shift_d = {shift_q[5:0], serialIn};
        bitCnt_d = bitCnt_q + 3'h1;
        // Eighth bit settles half a serial period after the start toggle, well before clk reads it
        if (bitCnt_q == 3'h7) begin
          byteHold_d = {shift_q, serialIn};
          framing_d = 1'b0;
        end
      end
    end
  end

  // Select pulse arms a new start bit; asynchronous clear of framing on select high
  always_ff @(posedge serialClk or posedge chipSelectN or negedge rstn) begin
    if (!rstn) begin
      bitCnt_q <= 3'h0;
      framing_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (chipSelectN) begin
      framing_q <= 1'b0;
      bitCnt_q <= 3'h0;
      armed_q <= 1'b1;
    end else begin
      bitCnt_q <= bitCnt_d;
      framing_q <= framing_d;
      armed_q <= armed_d;
    end
  end

  // Data flops kept apart from the select clear; they hold while select is high
  always_ff @(posedge serialClk or negedge rstn) begin
    if (!rstn) begin
      shift_q <= 7'h00;
      byteHold_q <= 8'h00;
    end else begin
      shift_q <= shift_d;
      byteHold_q <= byteHold_d;
    end
  end

  // Seven bits in, conversion begins on the next falling edge
  logic pendStart;
  assign pendStart = framing_q && (bitCnt_q == 3'h7);
  always_comb begin
    byteTgl_d = byteTgl_q;
    if (pendStart) begin
      byteTgl_d = ~byteTgl_q;
    end
  end

  always_ff @(negedge serialClk or negedge rstn) begin
    if (!rstn) begin
      byteTgl_q <= 1'b0;
    end else begin
      byteTgl_q <= byteTgl_d;
    end
  end

  // Crossing of the start event into clk
  logic tglSync;
  logic tglSeen_q, tglSeen_d;
  sync_two_ff #(.WIDTH(1)) u_tglSync (.clk(clk), .rstn(rstn), .din(byteTgl_q), .dout(tglSync));
  logic startEvt;
  assign startEvt = tglSync ^ tglSeen_q;

  // Conversion core on clk
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_CAL} state_type;
  state_type state_q, state_d;
  logic [16:0] cnt_q, cnt_d;
  adc_seq_pkg::ctrl_byte_type ctrl_q, ctrl_d;
  logic [15:0] result_q, result_d;
  logic strobe_q, strobe_d;
  logic idle_q, idle_d;
  logic resTgl_q, resTgl_d;
  logic pwrdn_q, pwrdn_d;
  logic [5:0] convClks_q, convClks_d;
  sync_two_ff #(.WIDTH(1)) u_idleSync (.clk(serialClk), .rstn(rstn), .din(idle_q), .dout(sclkIdle));

  function automatic logic [5:0] clocks_for(input logic [1:0] m);
    clocks_for = (m == `MODE_LONG) ? 6'(`CLKS_LONG) : 6'(`CLKS_SHORT);
  endfunction

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ctrl_d = ctrl_q;
    result_d = result_q;
    strobe_d = strobe_q;
    idle_d = idle_q;
    resTgl_d = resTgl_q;
    pwrdn_d = pwrdn_q;
    convClks_d = convClks_q;
    tglSeen_d = tglSync;
    if (startEvt) begin
      ctrl_d = adc_seq_pkg::ctrl_byte_type'(byteHold_q);
      idle_d = 1'b0;
      convClks_d = clocks_for(byteHold_q[`BIT_MODE_HI:`BIT_MODE_LO]);
      unique case (byteHold_q[`BIT_MODE_HI:`BIT_MODE_LO])
        `MODE_CAL: begin
          state_d = ST_CAL;
          cnt_d = 17'(CAL_CYCLES);
          strobe_d = 1'b0;
          pwrdn_d = 1'b0;
        end
        `MODE_PWRDN: begin
          state_d = ST_IDLE;
          pwrdn_d = 1'b1;
          idle_d = 1'b1;
          strobe_d = 1'b1;
        end
        `MODE_SHORT, `MODE_LONG: begin
          state_d = ST_CONV;
          cnt_d = 17'(CONV_CYCLES);
          strobe_d = 1'b0;
          pwrdn_d = 1'b0;
        end
      endcase
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          idle_d = 1'b1;
        end
        ST_CONV: begin
          // Select state is not looked at, so conversion runs on
          if (cnt_q == 17'h00001) begin
            state_d = ST_IDLE;
            strobe_d = 1'b1;
            idle_d = 1'b1;
            result_d = ctrl_q.polarity ? analogSample : {~analogSample[15], analogSample[14:0]};
            resTgl_d = ~resTgl_q;
          end else begin
            cnt_d = cnt_q - 17'h00001;
          end
        end
        ST_CAL: begin
          if (cnt_q == 17'h00001) begin
            state_d = ST_IDLE;
            strobe_d = 1'b1;
            idle_d = 1'b1;
          end else begin
            cnt_d = cnt_q - 17'h00001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cnt_q <= 17'h00000;
      ctrl_q <= '0;
      result_q <= 16'h0000;
      strobe_q <= 1'b1;
      idle_q <= 1'b1;
      resTgl_q <= 1'b0;
      pwrdn_q <= 1'b0;
      convClks_q <= 6'(`CLKS_SHORT);
      tglSeen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ctrl_q <= ctrl_d;
      result_q <= result_d;
      strobe_q <= strobe_d;
      idle_q <= idle_d;
      resTgl_q <= resTgl_d;
      pwrdn_q <= pwrdn_d;
      convClks_q <= convClks_d;
      tglSeen_q <= tglSeen_d;
    end
  end

  // Shutdown pin is asynchronous to clk
  logic offReq, offSync;
  assign offReq = ~shutdown_n;
  sync_two_ff #(.WIDTH(1)) u_offSync (.clk(clk), .rstn(rstn), .din(offReq), .dout(offSync));

  // Shutdowns touch neither the port register nor its drive
  assign userOut = ctrl_q.userOut;
  assign conversion_strobe = strobe_q;
  assign polarity_select = ctrl_q.polarity;
  assign clock_source_select = ctrl_q.clockSource;
  assign powerDown = pwrdn_q | offSync;
  assign calibrating = (state_q == ST_CAL);

  // Output shifter on falling serial edges; result word is stable when its toggle arrives
  logic resSync;
  logic resSeen_q, resSeen_d;
  logic [15:0] outShift_q, outShift_d;
  sync_two_ff #(.WIDTH(1)) u_resSync (.clk(serialClk), .rstn(rstn), .din(resTgl_q), .dout(resSync));
  always_comb begin
    resSeen_d = resSync;
    outShift_d = {outShift_q[14:0], 1'b0};
    if (resSync != resSeen_q) begin
      outShift_d = result_q;
    end
  end
  always_ff @(negedge serialClk or negedge rstn) begin
    if (!rstn) begin
      resSeen_q <= 1'b0;
      outShift_q <= 16'h0000;
    end else begin
      resSeen_q <= resSeen_d;
      outShift_q <= outShift_d;
    end
  end
  assign serialOut = outShift_q[15];
  assign serialOutEn = ~chipSelectN;

  property p_strobeMax;
    @(posedge clk) disable iff (!rstn) $fell(strobe_q) && state_q == ST_CONV |-> ##[1:300] strobe_q || startEvt;
  endproperty
  a_strobeMax: assert property (p_strobeMax) else $error("strobe low too long");
  property p_strobeEnd;
    @(posedge clk) disable iff (!rstn) state_q == ST_CONV && state_d == ST_IDLE |=> strobe_q && idle_q;
  endproperty
  a_strobeEnd: assert property (p_strobeEnd) else $error("strobe not high at end");
  property p_startLow;
    @(posedge clk) disable iff (!rstn) startEvt && state_d == ST_CONV |=> !strobe_q;
  endproperty
  a_startLow: assert property (p_startLow) else $error("strobe not low at start");
  property p_userLatch;
    @(posedge clk) disable iff (!rstn) startEvt |=> userOut == $past(byteHold_q[2:0]);
  endproperty
  a_userLatch: assert property (p_userLatch) else $error("user outputs not latched");
  property p_userHold;
    @(posedge clk) disable iff (!rstn) !startEvt |=> $stable(userOut);
  endproperty
  a_userHold: assert property (p_userHold) else $error("user outputs changed");
  property p_pwrdn;
    @(posedge clk) disable iff (!rstn) startEvt && byteHold_q[4:3] == `MODE_PWRDN |=> pwrdn_q && state_q == ST_IDLE;
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("power-down not entered");
  property p_cal;
    @(posedge clk) disable iff (!rstn) startEvt && byteHold_q[4:3] == `MODE_CAL |=> calibrating;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration not started");
  property p_clks;
    @(posedge clk) disable iff (!rstn) startEvt && byteHold_q[4:3] == `MODE_LONG |=> convClks_q == 6'h20;
  endproperty
  a_clks: assert property (p_clks) else $error("long mode clock count wrong");
  property p_code;
    @(posedge clk) disable iff (!rstn) $changed(resTgl_q) && !ctrl_q.polarity |-> result_q[15] == ~$past(analogSample[15]);
  endproperty
  a_code: assert property (p_code) else $error("bipolar coding wrong");
endmodule

// ==== tb/host_serial_master.sv ====
// Purpose: Host model acting as serial master for the control sequencer
// Assumes: Link clock period 15 ns, parked low between frames
// Notes: Data line shows inverted last value while select is high
`timescale 1ns/10ps
module host_serial_master #(
  parameter real HALF_NS = 7.5 // bench link faster than host limit; logic has a rate floor, half period under two clk periods
) (
  output logic serialClk, // Serial clock to device
  output logic chipSelectN, // Select, active low
  output logic serialIn, // Control data to device
  input wire logic serialOut, // Result data from device
  input wire logic serialOutEn // Device drives result line
);
  initial begin
    serialClk = 1'b0;
    chipSelectN = 1'b1;
    serialIn = 1'b0;
  end
  task automatic clock_bit(input logic b, output logic seen);
    serialIn = b;
    #(HALF_NS);
    seen = serialOutEn ? serialOut : 1'bx;
    serialClk = 1'b1;
    #(HALF_NS) serialClk = 1'b0;
  endtask
  // Three leading zeros, then the byte MSB first
  task automatic send_byte(input logic [7:0] b);
    logic s;
    chipSelectN = 1'b0;
    for (int k = 0; k < 11; k++) begin
      clock_bit(k < 3 ? 1'b0 : b[10-k], s);
    end
    #(HALF_NS) chipSelectN = 1'b1;
    serialIn = ~serialIn;
  endtask
  // Clock stays parked low until the next frame
  task automatic read_bits(output logic [23:0] w);
    logic s;
    #(HALF_NS) chipSelectN = 1'b0;
    for (int k = 0; k < 24; k++) begin
      clock_bit(1'b0, s);
      w[23-k] = s;
    end
    #(HALF_NS) chipSelectN = 1'b1;
    serialIn = ~serialIn;
  endtask
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #(HALF_NS) serialClk = 1'b1;
      #(HALF_NS) serialClk = 1'b0;
    end
  endtask
endmodule

// ==== tb/test_adc_serial_control_sequencer.sv ====
// Purpose: Self-checking bench for the serial control sequencer
// Assumes: Host model drives the serial link
// Notes: Short counts via parameters keep the run brief
`timescale 1ns/10ps
`define CHECK(nm, exp, got) begin nCompared++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] %s exp=%0h got=%0h", nm, exp, got); end end
module test_adc_serial_control_sequencer;
  localparam int CONV = 20;
  localparam int CAL = 50;
  typedef struct {
    logic [7:0] ctrl;
    logic [15:0] sample;
    int lowLen;
  } row_type;
  row_type rows [5] = '{'{8'he5, 16'h1234, CONV}, '{8'hbe, 16'hc3a5, CONV}, '{8'ha9, 16'h0000, CAL},
    '{8'hd3, 16'h0000, 0}, '{8'hfa, 16'h8001, CONV}};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic shutdown_n = 1'b1;
  logic [15:0] analogSample = 16'h0000;
  logic serialClk, chipSelectN, serialIn, serialOut, serialOutEn, conversion_strobe;
  logic [2:0] userOut;
  logic polarity_select, clock_source_select, powerDown, calibrating, calSeen;
  logic [23:0] bits;
  logic [15:0] expv;
  int errors = 0;
  int nCompared = 0;
  int cycles = 0;
  int cnt;
  always #12.5 clk = ~clk;
  adc_serial_control_sequencer #(.CONV_CYCLES(CONV), .CAL_CYCLES(CAL)) uut (.clk(clk), .rstn(rstn),
    .serialClk(serialClk), .chipSelectN(chipSelectN), .serialIn(serialIn), .shutdown_n(shutdown_n),
    .analogSample(analogSample), .serialOut(serialOut), .serialOutEn(serialOutEn),
    .conversion_strobe(conversion_strobe), .userOut(userOut), .polarity_select(polarity_select),
    .clock_source_select(clock_source_select), .powerDown(powerDown), .calibrating(calibrating));
  host_serial_master host (.serialClk(serialClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutEn(serialOutEn));
  task automatic final_report;
    $display("compared %0d mismatches %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #2;
  endtask
  // Wait up to 10 cycles for the strobe to fall, then count low cycles
  task automatic measure_low(output int n, output logic cal);
    int w;
    n = 0;
    w = 0;
    while (conversion_strobe === 1'b1 && w < 10) begin
      tick;
      w++;
    end
    cal = calibrating;
    while (conversion_strobe === 1'b0 && n < 200) begin
      tick;
      n++;
    end
  endtask
  // Result load lags the strobe by a few falls, so allow a small offset
  function automatic logic has_word(logic [23:0] b, logic [15:0] w);
    has_word = 1'b0;
    for (int k = 0; k <= 8; k++) begin
      if (b[23-k -: 16] === w) has_word = 1'b1;
    end
  endfunction
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    fork
      host.idle_clocks(4);
    join_none
    repeat (4) @(posedge clk);
    #2 rstn = 1'b1;
    `CHECK("userOut", 3'h0, userOut)
    `CHECK("strobe", 1'b1, conversion_strobe)
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      tick;
      analogSample = rows[i].sample;
      host.send_byte(rows[i].ctrl);
      measure_low(cnt, calSeen);
      `CHECK("lowLen", 1'b1, cnt >= rows[i].lowLen && cnt <= rows[i].lowLen + 2)
      `CHECK("calibrating", rows[i].ctrl[4:3] == 2'h1, calSeen)
      `CHECK("powerDown", rows[i].ctrl[4:3] == 2'h2, powerDown)
      `CHECK("userOut", rows[i].ctrl[2:0], userOut)
      `CHECK("polarity", rows[i].ctrl[6], polarity_select)
      `CHECK("clockSource", rows[i].ctrl[5], clock_source_select)
      if (rows[i].lowLen == CONV) begin
        expv = rows[i].ctrl[6] ? rows[i].sample : rows[i].sample ^ 16'h8000;
        host.read_bits(bits);
        `CHECK("result", 1'b1, has_word(bits, expv))
      end
      $display("test row %0d done", i);
    end
    host.read_bits(bits);
    measure_low(cnt, calSeen);
    `CHECK("noStart", 0, cnt)
    $display("test zeros done");
    host.send_byte(8'he0);
    repeat (6) tick;
    host.send_byte(8'he7);
    measure_low(cnt, calSeen);
    `CHECK("restart", 1'b1, cnt >= CONV - 1 && cnt <= CONV + 6)
    `CHECK("userOut", 3'h7, userOut)
    $display("test abort done");
    tick;
    shutdown_n = 1'b0;
    repeat (3) tick;
    `CHECK("powerDown", 1'b1, powerDown)
    `CHECK("userOut", 3'h7, userOut)
    shutdown_n = 1'b1;
    $display("test shutdown done");
    host.send_byte(8'he2);
    repeat (5) tick;
    `CHECK("strobe", 1'b0, conversion_strobe)
    tick;
    rstn = 1'b0;
    host.idle_clocks(3);
    tick;
    `CHECK("userOut", 3'h0, userOut)
    `CHECK("strobe", 1'b1, conversion_strobe)
    rstn = 1'b1;
    tick;
    host.send_byte(8'hc1);
    measure_low(cnt, calSeen);
    `CHECK("afterReset", 1'b1, cnt >= CONV && cnt <= CONV + 2)
    `CHECK("userOut", 3'h1, userOut)
    $display("test midreset done");
    final_report;
  end
endmodule
